// File: design/lite_timebase_counter.v
// Purpose: lite timer counter 2, reload, status flags and interrupt requests
// Assumes: apb3 slave, 32-bit data, zero wait states
// Notes:   timebase 1 and capture events arrive as pins and are synchronised
`timescale 1ns/1ps
`include "lite_timebase_consts.vh"
// Function
// [R01] in slow mode count clock is oscillator divided by 32
// [R02] wait and active-halt do not change counting
// [R03] halt stops the counter and holds all state; code stops only counter 2, flags and registers still change
// [R04] timebase and capture events drive separate interrupt outputs
// [R05] interrupt needs its enable bit set and cpu global mask clear
// [R06] software writes zero to reserved bits 7:2 of timebase-2 register
// [R07] bit 1 of timebase-2 register is read/write interrupt enable
// [R08] counter 2 overflow sets bit 0 of timebase-2 register
// [R09] reading timebase-2 register clears its flag; writes leave it
// [R10] reload register read/write, copied into counter 2 on overflow
// [R11] counter 2 value readable, writes ignored
// [R12] timebase-2, reload and counter registers reset to zero
// [R13] bit 7 of main register is capture interrupt enable
// [R14] main register resets to zero except undefined capture flag
// [R15] in active-halt the counter keeps running from oscillator
// [R16] only timebase 1 wakes active-halt; timebase 2 wakes wait only
// [R17] counter increments per tick, overflow reloads and sets flag
module lite_timebase_counter (
   input  wire        ref_clk_in,
   input  wire        rstn_in,
   input  wire        psel_in,
   input  wire        penable_in,
   input  wire        pwrite_in,
   input  wire [7:0]  paddr_in,
   input  wire [31:0] pwdata_in,
   output reg  [31:0] prdata_out,
   output reg         pready_out,
   output reg         pslverr_out,
   input  wire        cpu_irq_mask_in,
   input  wire        tb1_event_in,
   input  wire        capture_event_in,
   output reg         tb1_irq_out,
   output reg         tb2_irq_out,
   output reg         capture_irq_out,
   output reg         wakeup_out
);

   // register state
   reg  [7:0]  counter2_current_value;
   reg  [7:0]  counter2_reload_value;
   reg         timebase2_irq_enable;
   reg         timebase2_overflow_flag;
   reg         timebase1_irq_enable;
   reg         timebase1_event_flag;
   reg         capture_irq_enable;
   reg         capture_event_flag;
   reg  [3:0]  power_mode;
   // pin synchronisers and edge detect
   reg  [1:0]  tb1_sync;
   reg  [1:0]  cap_sync;
   reg         tb1_prev;
   reg         cap_prev;
   reg  [1:0]  mask_sync;
   reg  [7:0]  next_rdata;
   reg         next_err;

   wire        tick;
   wire        mode_slow   = power_mode[`BIT_MODE_SLOW];
   wire        mode_halt   = power_mode[`BIT_MODE_HALT];
   wire        mode_wait   = power_mode[`BIT_MODE_WAIT];
   wire        mode_ahalt  = power_mode[`BIT_MODE_ACTIVE_HALT];
   wire        setup       = psel_in && !penable_in;
   wire        access      = psel_in && penable_in;
   wire        wr          = access && pwrite_in;
   wire        rd          = access && !pwrite_in;
   wire        overflow    = tick && (counter2_current_value == 8'hFF);
   wire        tb1_rise    = tb1_sync[1] && !tb1_prev;
   wire        cap_rise    = cap_sync[1] && !cap_prev;
   wire        irq_allowed = !mask_sync[1];

   // true when the address decodes to a mapped register
   function mapped;
      input [7:0] a;
      begin
         mapped = (a == `ADDR_MAIN_CTRL_STATUS) || (a == `ADDR_TB2_CTRL_STATUS) ||
                  (a == `ADDR_RELOAD_VALUE) || (a == `ADDR_CURRENT_VALUE) ||
                  (a == `ADDR_POWER_MODE) || (a == `ADDR_EVENT_PULSE);
      end
   endfunction

   // count enable; only halt freezes it, wait and active-halt keep it running
   timebase_tick_gen #(
      .DIVIDE   (`SLOW_DIVIDE),
      .DIV_BITS (`SLOW_DIV_BITS)
   ) u_tick (
      .ref_clk_in (ref_clk_in),
      .rstn_in    (rstn_in),
      .slow_in    (mode_slow),          // see [R01]
      .stop_in    (mode_halt),          // see [R03] see [R02] see [R15]
      .tick_out   (tick)
   );

   // two-stage synchronisers; first stage feeds only the second
   always @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         tb1_sync  <= 2'h0;
         cap_sync  <= 2'h0;
         mask_sync <= 2'h3;
         tb1_prev  <= 1'b0;
         cap_prev  <= 1'b0;
      end else begin
         tb1_sync  <= {tb1_sync[0], tb1_event_in};
         cap_sync  <= {cap_sync[0], capture_event_in};
         mask_sync <= {mask_sync[0], cpu_irq_mask_in};
         tb1_prev  <= tb1_sync[1];
         cap_prev  <= cap_sync[1];
      end
   end

   // counter 2 with automatic reload
   always @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         counter2_current_value <= `RST_CURRENT_VALUE;          // see [R12]
      end else if (overflow) begin
         counter2_current_value <= counter2_reload_value;       // see [R10] see [R17]
      end else if (tick) begin
         counter2_current_value <= counter2_current_value + 8'h01; // see [R17]
      end
   end

   // software registers; counter register has no write path
   always @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         counter2_reload_value <= `RST_RELOAD_VALUE;            // see [R12]
         timebase2_irq_enable  <= 1'b0;
         timebase1_irq_enable  <= 1'b0;
         capture_irq_enable    <= 1'b0;                         // see [R14]
         power_mode            <= `RST_POWER_MODE;
      end else if (wr) begin
         case (paddr_in)
            `ADDR_RELOAD_VALUE: begin
               counter2_reload_value <= pwdata_in[7:0];         // see [R10]
            end
            `ADDR_TB2_CTRL_STATUS: begin
               timebase2_irq_enable <= pwdata_in[`BIT_TB2_IE];  // see [R07]
            end
            `ADDR_MAIN_CTRL_STATUS: begin
               capture_irq_enable   <= pwdata_in[`BIT_CAP_IE];  // see [R13]
               timebase1_irq_enable <= pwdata_in[`BIT_TB1_IE];
            end
            `ADDR_POWER_MODE: begin
               power_mode <= pwdata_in[3:0];
            end
            default: begin
               power_mode <= power_mode;                        // see [R11]
            end
         endcase
      end
   end

   // sticky flags: hardware set wins over clear-on-read in the same cycle
   always @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         timebase2_overflow_flag <= 1'b0;                       // see [R12]
         timebase1_event_flag    <= 1'b0;
         capture_event_flag      <= 1'b0;   // value may be undefined, held at zero; see [R14]
      end else begin
         if (overflow) begin
            timebase2_overflow_flag <= 1'b1;                    // see [R08] see [R17]
         end else if (rd && paddr_in == `ADDR_TB2_CTRL_STATUS) begin
            timebase2_overflow_flag <= 1'b0;                    // see [R09]
         end
         if (tb1_rise || (wr && paddr_in == `ADDR_EVENT_PULSE && pwdata_in[`BIT_PULSE_TB1])) begin
            timebase1_event_flag <= 1'b1;
         end else if (rd && paddr_in == `ADDR_MAIN_CTRL_STATUS) begin
            timebase1_event_flag <= 1'b0;
         end
         if (cap_rise || (wr && paddr_in == `ADDR_EVENT_PULSE && pwdata_in[`BIT_PULSE_CAP])) begin
            capture_event_flag <= 1'b1;
         end else if (rd && paddr_in == `ADDR_MAIN_CTRL_STATUS) begin
            capture_event_flag <= 1'b0;
         end
      end
   end

   // read mux; reserved bits read zero
   always @* begin
      next_rdata = 8'h00;
      next_err   = !mapped(paddr_in);
      case (paddr_in)
         `ADDR_MAIN_CTRL_STATUS: begin
            next_rdata = {capture_irq_enable, capture_event_flag, timebase1_irq_enable,
                          timebase1_event_flag, 4'h0};
         end
         `ADDR_TB2_CTRL_STATUS: begin
            next_rdata = {6'h00, timebase2_irq_enable, timebase2_overflow_flag}; // see [R06]
         end
         `ADDR_RELOAD_VALUE: begin
            next_rdata = counter2_reload_value;
         end
         `ADDR_CURRENT_VALUE: begin
            next_rdata = counter2_current_value;                // see [R11]
         end
         `ADDR_POWER_MODE: begin
            next_rdata = {4'h0, power_mode};
         end
         default: begin
            next_rdata = 8'h00;
         end
      endcase
   end

   // apb answer: data registered in setup, ready high for the access cycle
   always @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         prdata_out  <= 32'h00000000;
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
      end else begin
         pready_out  <= setup;
         pslverr_out <= setup && next_err;
         if (setup && !pwrite_in) begin
            prdata_out <= {24'h000000, next_rdata};
         end
      end
   end

   // separate request lines, each gated by enable and global mask
   always @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         tb1_irq_out     <= 1'b0;
         tb2_irq_out     <= 1'b0;
         capture_irq_out <= 1'b0;
         wakeup_out      <= 1'b0;
      end else begin
         tb1_irq_out     <= timebase1_event_flag && timebase1_irq_enable && irq_allowed;  // see [R04] see [R05]
         tb2_irq_out     <= timebase2_overflow_flag && timebase2_irq_enable && irq_allowed; // see [R04] see [R05]
         capture_irq_out <= capture_event_flag && capture_irq_enable && irq_allowed;      // see [R05]
         // halt is never left by a timer event; active-halt only by timebase 1
         wakeup_out      <= !mode_halt &&
                            ((timebase1_event_flag && timebase1_irq_enable && (mode_ahalt || mode_wait)) ||
                             (timebase2_overflow_flag && timebase2_irq_enable && mode_wait && !mode_ahalt) ||
                             (capture_event_flag && capture_irq_enable && mode_wait && !mode_ahalt)); // see [R16]
      end
   end

endmodule

// File: design/lite_timebase_consts.vh
// Purpose: constants for the lite timebase counter block
// Assumes: apb byte addresses, one register per aligned word
// Notes:   definitions only
`ifndef LITE_TIMEBASE_CONSTS_VH
`define LITE_TIMEBASE_CONSTS_VH

// register byte offsets
`define ADDR_MAIN_CTRL_STATUS  8'h00
`define ADDR_TB2_CTRL_STATUS   8'h04
`define ADDR_RELOAD_VALUE      8'h08
`define ADDR_CURRENT_VALUE     8'h0C
`define ADDR_POWER_MODE        8'h10
`define ADDR_EVENT_PULSE       8'h14

// field positions
`define BIT_TB2_FLAG           0
`define BIT_TB2_IE             1
`define BIT_TB1_FLAG           4
`define BIT_TB1_IE             5
`define BIT_CAP_FLAG           6
`define BIT_CAP_IE             7
`define BIT_MODE_SLOW          0
`define BIT_MODE_HALT          1
`define BIT_MODE_WAIT          2
`define BIT_MODE_ACTIVE_HALT   3
`define BIT_PULSE_TB1          0
`define BIT_PULSE_CAP          1

// reset values
`define RST_TB2_CTRL_STATUS    8'h00
`define RST_RELOAD_VALUE       8'h00
`define RST_CURRENT_VALUE      8'h00
`define RST_MAIN_CTRL_STATUS   8'h00
`define RST_POWER_MODE         4'h0

// timing: oscillator divided by this in slow mode
`define SLOW_DIVIDE            32
`define SLOW_DIV_BITS          5

`endif

// File: design/timebase_tick_gen.v
// Purpose: produce the count enable tick for counter 2
// Assumes: ref clock is the oscillator
// Notes:   in slow mode one tick per divide ratio, else every cycle; no tick while stopped
`timescale 1ns/1ps
`include "lite_timebase_consts.vh"
module timebase_tick_gen #(
   parameter DIVIDE    = `SLOW_DIVIDE,
   parameter DIV_BITS  = `SLOW_DIV_BITS
) (
   input  wire       ref_clk_in,
   input  wire       rstn_in,
   input  wire       slow_in,
   input  wire       stop_in,
   output reg        tick_out
);

   reg  [DIV_BITS-1:0] div_count;

   // divider runs off the oscillator, not the cpu divider; frozen while stopped
   always @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         div_count <= {DIV_BITS{1'b0}};
         tick_out  <= 1'b0;
      end else if (stop_in) begin
         tick_out  <= 1'b0;
      end else if (!slow_in) begin
         div_count <= {DIV_BITS{1'b0}};
         tick_out  <= 1'b1;
      end else begin
         div_count <= div_count + {{(DIV_BITS-1){1'b0}}, 1'b1};
         tick_out  <= (div_count == DIVIDE[DIV_BITS-1:0] - {{(DIV_BITS-1){1'b0}}, 1'b1}); // see [R01]
      end
   end

endmodule

// File: sim/lite_timebase_assertions.sv
// Purpose: port checks for the lite timebase counter
// Assumes: zero wait state apb, two flop mask synchroniser
// Notes:   bound to every instance of the top module
`timescale 1ns/1ps
module lite_timebase_assertions (
   input wire        ref_clk_in,
   input wire        rstn_in,
   input wire        psel_in,
   input wire        penable_in,
   input wire        pwrite_in,
   input wire [7:0]  paddr_in,
   input wire [31:0] prdata_out,
   input wire        pready_out,
   input wire        pslverr_out,
   input wire        cpu_irq_mask_in,
   input wire        tb1_irq_out,
   input wire        tb2_irq_out,
   input wire        capture_irq_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rstn_in);
   // bus answer: one pulse per setup, never unasked
   chk_ready_after_setup: assert property (psel_in && !penable_in |=> pready_out)
      else $error("ready missing after setup");
   chk_ready_one_cycle: assert property (pready_out |=> !pready_out)
      else $error("ready held too long");
   chk_no_stray_ready: assert property (!psel_in |=> !pready_out)
      else $error("ready without request");
   chk_err_with_ready: assert property (pslverr_out |-> pready_out)
      else $error("error without ready");
   chk_unmapped_error: assert property (psel_in && !penable_in && paddr_in[1:0] == 2'b00
      |=> pslverr_out == ($past(paddr_in) > 8'h14)) else $error("error flag wrong for address");
   // registers are 8 bits, upper lanes must stay clear
   chk_upper_data_zero: assert property (pready_out |-> prdata_out[31:8] == 24'h000000)
      else $error("upper read data not zero");
   chk_rdata_held: assert property (psel_in && pwrite_in |=> $stable(prdata_out))
      else $error("read data moved during write");
   // sync adds latency, so four masked cycles are needed before all go quiet
   chk_mask_blocks_irq: assert property (cpu_irq_mask_in [*4] |-> !(tb1_irq_out || tb2_irq_out || capture_irq_out))
      else $error("request while masked");
   cover property (pready_out && pslverr_out);
   cover property ($rose(tb2_irq_out));
   cover property ($rose(capture_irq_out));
endmodule
bind lite_timebase_counter lite_timebase_assertions i_chk (.ref_clk_in, .rstn_in, .psel_in, .penable_in, .pwrite_in,
   .paddr_in, .prdata_out, .pready_out, .pslverr_out, .cpu_irq_mask_in, .tb1_irq_out, .tb2_irq_out, .capture_irq_out);

// File: sim/testbench.sv
// Purpose: self-checking bench for the lite timebase counter
// Assumes: zero wait state apb slave, 10 MHz reference clock
// Notes:   counter phase is unknown, so halt is used to freeze it
`timescale 1ns/1ps
`include "lite_timebase_consts.vh"
module testbench;
   reg         ref_clk_in = 1'b0;
   reg         rstn_in = 1'b0;
   reg         psel_in = 1'b0;
   reg         penable_in = 1'b0;
   reg         pwrite_in = 1'b0;
   reg  [7:0]  paddr_in = 8'h00;
   reg  [31:0] pwdata_in = 32'h00000000;
   reg         cpu_irq_mask_in = 1'b1;
   reg         tb1_event_in = 1'b0;
   reg         capture_event_in = 1'b0;
   wire [31:0] prdata_out;
   wire        pready_out;
   wire        pslverr_out;
   wire        tb1_irq_out;
   wire        tb2_irq_out;
   wire        capture_irq_out;
   wire        wakeup_out;
   integer     errors = 0;
   integer     total_checks = 0;
   reg  [31:0] rd;
   reg  [31:0] a0;
   reg         slverr;
   integer     m;
   lite_timebase_counter i_dut (.ref_clk_in, .rstn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
      .prdata_out, .pready_out, .pslverr_out, .cpu_irq_mask_in, .tb1_event_in, .capture_event_in, .tb1_irq_out,
      .tb2_irq_out, .capture_irq_out, .wakeup_out);
   // 100 ns reference clock
   always #50 ref_clk_in = ~ref_clk_in;
   task check(input [31:0] seen, input [31:0] exp);
      begin
         total_checks = total_checks + 1;
         if (seen !== exp) begin
            errors = errors + 1;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   // one apb transfer; request held until pready is sampled high
   task xfer(input w, input [7:0] a, input [31:0] d);
      integer n;
      begin
         @(posedge ref_clk_in);
         psel_in <= 1'b1;
         pwrite_in <= w;
         paddr_in <= a;
         pwdata_in <= d;
         @(posedge ref_clk_in);
         penable_in <= 1'b1;
         n = 0;
         @(posedge ref_clk_in);
         while (pready_out !== 1'b1 && n < 20) begin
            n = n + 1;
            @(posedge ref_clk_in);
         end
         // limit ran out with no answer: counts as a mismatch
         if (pready_out !== 1'b1) errors = errors + 1;
         rd = prdata_out;
         slverr = pslverr_out;
         psel_in <= 1'b0;
         penable_in <= 1'b0;
      end
   endtask
   task wr(input [7:0] a, input [7:0] d); xfer(1'b1, a, {24'h000000, d}); endtask
   task rdchk(input [7:0] a, input [7:0] e); begin xfer(1'b0, a, 32'h0); check(rd, {24'h000000, e}); end endtask
   task tick(input integer n); repeat (n) @(posedge ref_clk_in); endtask
   // counter is read first: its first tick lands on that read's setup edge, after the value is taken
   task t_reset;
      begin
         rdchk(`ADDR_CURRENT_VALUE, 8'h00);
         rdchk(`ADDR_MAIN_CTRL_STATUS, 8'h00);
         rdchk(`ADDR_TB2_CTRL_STATUS, 8'h00);
         rdchk(`ADDR_RELOAD_VALUE, 8'h00);
      end
   endtask
   // halted: counter frozen, so writes to it are visible as ignored
   task t_regs;
      begin
         wr(`ADDR_POWER_MODE, 8'h02);
         xfer(1'b0, `ADDR_CURRENT_VALUE, 32'h0);
         a0 = rd;
         wr(`ADDR_CURRENT_VALUE, 8'h55);
         rdchk(`ADDR_CURRENT_VALUE, a0[7:0]);
         wr(`ADDR_RELOAD_VALUE, 8'hA5);
         rdchk(`ADDR_RELOAD_VALUE, 8'hA5);
         wr(`ADDR_MAIN_CTRL_STATUS, 8'hA0);
         rdchk(`ADDR_MAIN_CTRL_STATUS, 8'hA0);
         wr(`ADDR_MAIN_CTRL_STATUS, 8'h00);
         // test pulse sets both event flags, one read of the main register clears them
         wr(`ADDR_EVENT_PULSE, 8'h03);
         rdchk(`ADDR_MAIN_CTRL_STATUS, 8'h50);
         rdchk(`ADDR_MAIN_CTRL_STATUS, 8'h00);
         rdchk(8'h18, 8'h00);
         check({31'h0, slverr}, 32'h1);
      end
   endtask
   task t_overflow;
      begin
         wr(`ADDR_RELOAD_VALUE, 8'hFF);
         wr(`ADDR_POWER_MODE, 8'h00);
         tick(300);
         wr(`ADDR_POWER_MODE, 8'h02);
         rdchk(`ADDR_CURRENT_VALUE, 8'hFF);
         // writing zero to a set flag must not clear it
         wr(`ADDR_TB2_CTRL_STATUS, 8'h00);
         rdchk(`ADDR_TB2_CTRL_STATUS, 8'h01);
         rdchk(`ADDR_TB2_CTRL_STATUS, 8'h00);
         wr(`ADDR_TB2_CTRL_STATUS, 8'h03);
         rdchk(`ADDR_TB2_CTRL_STATUS, 8'h02);
         wr(`ADDR_TB2_CTRL_STATUS, 8'h00);
         tick(40);
         rdchk(`ADDR_TB2_CTRL_STATUS, 8'h00);
         // slow mode: about eight ticks in 259 clocks, first one reloads
         wr(`ADDR_RELOAD_VALUE, 8'h10);
         wr(`ADDR_POWER_MODE, 8'h01);
         tick(256);
         wr(`ADDR_POWER_MODE, 8'h02);
         xfer(1'b0, `ADDR_CURRENT_VALUE, 32'h0);
         check({31'h0, rd >= 32'h16 && rd <= 32'h19}, 32'h1);
         rdchk(`ADDR_TB2_CTRL_STATUS, 8'h01);
      end
   endtask
   // wait and active-halt keep the counter moving, one count per clock
   task t_modes;
      for (m = 4; m <= 8; m = m + 4) begin
         wr(`ADDR_POWER_MODE, m[7:0]);
         xfer(1'b0, `ADDR_CURRENT_VALUE, 32'h0);
         a0 = rd;
         tick(20);
         xfer(1'b0, `ADDR_CURRENT_VALUE, 32'h0);
         // setup edges lie 23 clocks apart: 20 idle plus the last edge of the first transfer and two edges of the second
         check(rd, a0 + 32'd23);
      end
   endtask
   task t_irq;
      begin
         wr(`ADDR_RELOAD_VALUE, 8'hFF);
         wr(`ADDR_POWER_MODE, 8'h04);
         tick(300);
         wr(`ADDR_TB2_CTRL_STATUS, 8'h02);
         cpu_irq_mask_in <= 1'b0;
         tick(8);
         check({tb1_irq_out, tb2_irq_out, capture_irq_out, wakeup_out}, 32'h5);
         wr(`ADDR_POWER_MODE, 8'h08);
         tick(4);
         check(wakeup_out, 1'b0);
         cpu_irq_mask_in <= 1'b1;
         tick(8);
         check(tb2_irq_out, 1'b0);
         cpu_irq_mask_in <= 1'b0;
         wr(`ADDR_TB2_CTRL_STATUS, 8'h00);
         tick(4);
         check(tb2_irq_out, 1'b0);
         wr(`ADDR_MAIN_CTRL_STATUS, 8'h20);
         tb1_event_in <= 1'b1;
         tick(8);
         check({tb1_irq_out, capture_irq_out, wakeup_out}, 32'h5);
         wr(`ADDR_MAIN_CTRL_STATUS, 8'h80);
         capture_event_in <= 1'b1;
         tick(8);
         check({tb1_irq_out, capture_irq_out, wakeup_out}, 32'h2);
         wr(`ADDR_MAIN_CTRL_STATUS, 8'hA0);
         wr(`ADDR_POWER_MODE, 8'h02);
         tick(4);
         check(wakeup_out, 1'b0);
      end
   endtask
   // mid-run reset; pins low first, else a rise right after release sets the flags
   task t_rerun;
      begin
         tb1_event_in     <= 1'b0;
         capture_event_in <= 1'b0;
         rstn_in          <= 1'b0;
         tick(2);
         check({tb1_irq_out, tb2_irq_out, capture_irq_out, wakeup_out}, 32'h0);
         rstn_in <= 1'b1;
         t_reset;
      end
   endtask
   task results;
      begin
         $display("checks %0d errors %0d", total_checks, errors);
         if (errors == 0 && total_checks > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   // run well under 2000 cycles, so 5000 means a hang
   initial begin
      #500000;
      errors = errors + 1;
      results;
   end
   initial begin
      repeat (3) @(posedge ref_clk_in);
      rstn_in <= 1'b1;
      t_reset;
      t_regs;
      t_overflow;
      t_modes;
      t_irq;
      t_rerun;
      results;
   end
endmodule
